/* hw/rivag_prio_enc.sv */
// Lowest-index priority encoder over the taken interrupt requests.
// Assumes requests already qualified by enables in the caller.
module rivag_prio_enc (
  input  wire logic [21:0] req,
  output logic             any,
  output logic [4:0]       idx
);

  logic [21:0] lower_busy;

  // ----------------------------------------------------------------
  // One-hot select, lowest index wins
  // ----------------------------------------------------------------
  assign lower_busy[0] = 1'b0;
  for (genvar i = 1; i < 22; i++) begin : g_chain
    assign lower_busy[i] = lower_busy[i-1] | req[i-1];
  end

  always_comb begin
    idx = 5'h00;
    for (int i = 0; i < 22; i++) begin
      if (req[i] && !lower_busy[i]) begin
        idx = 5'(i);
      end
    end
  end

  assign any = |req;

endmodule

/* hw/rivag_vector_gen.sv */
// Reset and interrupt vector address generator, top level.
// Assumes the core asserts take_ack for one cycle when it loads
// the presented vector, and that sources hold requests as levels.
module rivag_vector_gen (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        boot_reset_select_fuse,
  input  wire logic        vector_table_relocate_bit,
  input  wire logic [15:0] boot_start_addr,
  input  wire logic        global_irq_en,
  input  wire logic [21:0] irq_req,
  input  wire logic [21:0] irq_en,
  input  wire logic        take_ack,
  output logic             reset_fetch,
  output logic [15:0]      reset_vec_addr,
  output logic             irq_valid,
  output logic [15:0]      irq_vec_addr,
  output logic [4:0]       irq_src_idx
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        rst_pend;
    logic [1:0]  settle;
    logic [15:0] rst_addr;
    logic        valid;
    logic [15:0] vaddr;
    logic [4:0]  idx;
  } rivag_state_s;

  rivag_state_s st_r;
  rivag_state_s st_nxt;

  logic [21:0] taken_req;
  logic        any_req;
  logic [4:0]  win_idx;
  logic [15:0] table_base;
  logic [15:0] reloc_off;
  logic        fuse_s1_r;
  logic        fuse_s2_r;

  // Fuse is a static strap but still synchronised before use
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fuse_s1_r <= 1'b1;
      fuse_s2_r <= 1'b1;
    end else begin
      fuse_s1_r <= boot_reset_select_fuse;
      fuse_s2_r <= fuse_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Qualification and priority
  // ----------------------------------------------------------------
  // Masked sources never reach the core, so their slots may hold code
  assign taken_req = irq_req & irq_en & {22{global_irq_en}};

  rivag_prio_enc u_prio (
    .req (taken_req),
    .any (any_req),
    .idx (win_idx)
  );

  // Slot n sits at 0x0002 + 2n: covers all fixed table entries
  assign table_base = rivag_pkg::VEC_BASE
                    + 16'({11'h000, win_idx} * rivag_pkg::VEC_STEP);
  assign reloc_off  = vector_table_relocate_bit ? boot_start_addr
                                                : 16'h0000;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Sync flops come out of reset at 1; wait until both hold the fuse
    if (st_r.rst_pend) begin
      if (st_r.settle != 2'h0) begin
        st_nxt.settle = st_r.settle - 2'h1;
      end else begin
        st_nxt.rst_pend = 1'b0;
        st_nxt.rst_addr = (fuse_s2_r == rivag_pkg::FUSE_UNPROG)
                        ? rivag_pkg::RESET_ADDR
                        : boot_start_addr;
      end
    end
    // Hold the presented vector stable until the core takes it
    if (!st_r.valid || take_ack) begin
      st_nxt.valid = any_req && !st_r.rst_pend;
      st_nxt.vaddr = table_base + reloc_off;
      st_nxt.idx   = win_idx;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '{rst_pend: 1'b1, settle: rivag_pkg::FUSE_SETTLE,
                rst_addr: rivag_pkg::RESET_ADDR,
                valid: 1'b0, vaddr: rivag_pkg::VEC_BASE, idx: 5'h00};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reset_fetch    = st_r.rst_pend;
  assign reset_vec_addr = st_r.rst_addr;
  assign irq_valid      = st_r.valid;
  assign irq_vec_addr   = st_r.vaddr;
  assign irq_src_idx    = st_r.idx;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_reset_unprog: assert property (@(posedge clk) disable iff (rst)
    $fell(st_r.rst_pend) && fuse_s2_r |-> reset_vec_addr == 16'h0000)
    else $error("reset address not zero");
  chk_reset_boot: assert property (@(posedge clk) disable iff (rst)
    $fell(st_r.rst_pend) && !$past(fuse_s2_r)
    |-> reset_vec_addr == $past(boot_start_addr))
    else $error("reset address not boot start");
  chk_fuse_indep: assert property (@(posedge clk) disable iff (rst)
    !reset_fetch && $stable(reset_vec_addr) |=> $stable(reset_vec_addr))
    else $error("reset address moved");
  chk_vec_first: assert property (@(posedge clk) disable iff (rst)
    irq_valid && irq_src_idx == 5'h00 && !$past(vector_table_relocate_bit)
    && $rose(irq_valid) |-> irq_vec_addr == 16'h0002)
    else $error("first vector wrong");
  chk_vec_reloc: assert property (@(posedge clk) disable iff (rst)
    $rose(irq_valid) && $past(vector_table_relocate_bit)
    |-> irq_vec_addr == 16'(16'h0002 + {11'h000, irq_src_idx, 1'b0}
                        + $past(boot_start_addr)))
    else $error("relocated vector wrong");
  chk_vec_last: assert property (@(posedge clk) disable iff (rst)
    $rose(irq_valid) && irq_src_idx == 5'd21
    && !$past(vector_table_relocate_bit) |-> irq_vec_addr == 16'h002c)
    else $error("last vector wrong");
  chk_only_taken: assert property (@(posedge clk) disable iff (rst)
    $rose(irq_valid)
    |-> ($past(taken_req) & (22'h1 << irq_src_idx)) != 22'h0)
    else $error("vector for untaken source");
  chk_lowest_first: assert property (@(posedge clk) disable iff (rst)
    $rose(irq_valid) |-> ($past(taken_req) & ((22'h1 << irq_src_idx)
                          - 22'h1)) == 22'h0)
    else $error("priority order broken");
  chk_hold_vec: assert property (@(posedge clk) disable iff (rst)
    irq_valid && !take_ack |=> irq_valid && $stable(irq_vec_addr))
    else $error("vector dropped before take");

  cov_reset_boot: cover property (@(posedge clk) disable iff (rst)
    $fell(st_r.rst_pend) && !fuse_s2_r);
  cov_reloc_take: cover property (@(posedge clk) disable iff (rst)
    irq_valid && take_ack && vector_table_relocate_bit);
  cov_two_pending: cover property (@(posedge clk) disable iff (rst)
    $countones(taken_req) > 1 && !irq_valid);
  cov_lcd_taken: cover property (@(posedge clk) disable iff (rst)
    irq_valid && irq_src_idx == 5'd21 && take_ack);

endmodule

/* inc/rivag_pkg.sv */
// Package of the reset and interrupt vector address generator.
// Assumes a 16-bit word address space for program fetch.
package rivag_pkg;

  // ----------------------------------------------------------------
  // Address layout
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 16;
  localparam int          NUM_IRQ       = 22;
  localparam int          IDX_W         = 5;
  localparam logic [15:0] RESET_ADDR    = 16'h0000;
  localparam logic [15:0] VEC_BASE      = 16'h0002;
  localparam logic [15:0] VEC_STEP      = 16'h0002;
  localparam logic [15:0] LAST_VEC      = 16'h002c;
  // Default boot section start (1K-word boot section)
  localparam logic [15:0] BOOT_START_DEF = 16'h1c00;

  // Fuse encoding: 1 unprogrammed, 0 programmed
  localparam logic        FUSE_UNPROG   = 1'b1;
  // Edges after release before the fuse sync output is trusted
  localparam logic [1:0]  FUSE_SETTLE   = 2'h2;

  // ----------------------------------------------------------------
  // Source order, lowest index = highest priority
  // ----------------------------------------------------------------
  localparam int SRC_EXT0      = 0;
  localparam int SRC_PCH0      = 1;
  localparam int SRC_PCH1      = 2;
  localparam int SRC_T2_CMP    = 3;
  localparam int SRC_T2_OVF    = 4;
  localparam int SRC_T1_CAP    = 5;
  localparam int SRC_T1_CMPA   = 6;
  localparam int SRC_T1_CMPB   = 7;
  localparam int SRC_T1_OVF    = 8;
  localparam int SRC_T0_CMP    = 9;
  localparam int SRC_T0_OVF    = 10;
  localparam int SRC_SPI       = 11;
  localparam int SRC_UART_RX   = 12;
  localparam int SRC_UART_DRE  = 13;
  localparam int SRC_UART_TX   = 14;
  localparam int SRC_USI_START = 15;
  localparam int SRC_USI_OVF   = 16;
  localparam int SRC_ACMP      = 17;
  localparam int SRC_ADC       = 18;
  localparam int SRC_EEPROM    = 19;
  localparam int SRC_PSTORE    = 20;
  localparam int SRC_LCD       = 21;

endpackage

/* sim/rivag_core_model.sv */
// Core fetch model: takes each presented vector after a set stall.
// Assumes the clock and reset of the vector generator.
module rivag_core_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  stall,
  input  wire logic        irq_valid,
  input  wire logic [15:0] irq_vec_addr,
  input  wire logic [4:0]  irq_src_idx,
  output logic             take_ack,
  output logic [15:0]      got_addr,
  output logic [4:0]       got_idx,
  output int               got_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_r;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      take_ack <= 1'b0;
      wait_r   <= 4'h0;
      got_cnt  <= 0;
    end else if (irq_valid && !take_ack && wait_r == stall) begin
      take_ack <= 1'b1;
      got_addr <= irq_vec_addr;
      got_idx  <= irq_src_idx;
      got_cnt  <= got_cnt + 1;
      wait_r   <= 4'h0;
    end else begin
      // Ack is a single pulse; the next vector waits a full stall
      take_ack <= 1'b0;
      wait_r   <= (irq_valid && !take_ack) ? wait_r + 4'h1 : 4'h0;
    end
  end
endmodule

/* sim/rivag_vector_gen_tb.sv */
// Testbench of the vector generator with a core fetch model.
// Assumes sources clear their flag in the cycle the core acks.
module rivag_vector_gen_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] BOOT = rivag_pkg::BOOT_START_DEF;
  logic        clk, rst, fuse, reloc, gie, ack, rfetch, ivalid;
  logic [21:0] raise_r, pend_r, en, req, ack_mask;
  logic [15:0] raddr, vaddr, gaddr;
  logic [4:0]  vidx, gidx;
  logic [3:0]  stall;
  int          gcnt, num_errors, tests_run;
  // Flag clears on the ack edge, as a real source would
  assign ack_mask = ack ? 22'h1 << vidx : 22'h0;
  assign req = pend_r & ~ack_mask;
  always @(posedge clk) pend_r <= (pend_r | raise_r) & ~ack_mask;
  rivag_vector_gen u_rivag_vector_gen (.clk(clk), .rst(rst),
    .boot_reset_select_fuse(fuse), .vector_table_relocate_bit(reloc),
    .boot_start_addr(BOOT), .global_irq_en(gie), .irq_req(req),
    .irq_en(en), .take_ack(ack), .reset_fetch(rfetch),
    .reset_vec_addr(raddr), .irq_valid(ivalid), .irq_vec_addr(vaddr),
    .irq_src_idx(vidx));
  rivag_core_model u_rivag_core_model (.clk(clk), .rst(rst),
    .stall(stall), .irq_valid(ivalid), .irq_vec_addr(vaddr),
    .irq_src_idx(vidx), .take_ack(ack), .got_addr(gaddr),
    .got_idx(gidx), .got_cnt(gcnt));
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      num_errors++;
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic t_reset(logic f, logic r);
    fuse  <= f;
    reloc <= r;
    rst   <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check("reset_fetch_hold", {15'h0, rfetch}, 16'h0001);
    @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check("reset_fetch", {15'h0, rfetch}, 16'h0000);
    check("reset_vec_addr", raddr, f ? 16'h0000 : BOOT);
    @(posedge clk);
  endtask
  // Waits for the core to take one more vector, bounded
  task automatic take_one(logic [21:0] mask);
    int c0;
    c0 = gcnt;
    raise_r <= mask;
    @(posedge clk);
    raise_r <= 22'h0;
    for (int k = 0; k < 40 && gcnt == c0; k++) @(negedge clk);
    if (gcnt == c0) begin
      num_errors++;
      give_verdict();
    end
  endtask
  task automatic t_table(logic r, logic [3:0] s);
    reloc <= r;
    stall <= s;
    gie   <= 1'b1;
    en    <= '1;
    @(posedge clk);
    for (int i = 0; i < 22; i++) begin
      take_one(22'h1 << i);
      check("vec_addr", gaddr, (r ? BOOT : 16'h0) + 16'(2 * i + 2));
      check("src_idx", {11'h0, gidx}, 16'(i));
      @(posedge clk);
    end
  endtask
  task automatic t_mask_order();
    en      <= 22'h0;
    raise_r <= '1;
    @(posedge clk);
    raise_r <= 22'h0;
    repeat (10) @(negedge clk);
    check("masked_valid", {15'h0, ivalid}, 16'h0000);
    @(posedge clk);
    en  <= '1;
    gie <= 1'b0;
    repeat (10) @(negedge clk);
    check("gie_off_valid", {15'h0, ivalid}, 16'h0000);
    @(posedge clk);
    gie <= 1'b1;
    for (int k = 0; k < 22; k++) begin
      take_one(22'h0);
      check("order_idx", {11'h0, gidx}, 16'(k));
      @(posedge clk);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {rst, fuse, reloc, gie} = 4'b1100;
    {raise_r, pend_r, en} = '0;
    stall = 4'h0;
    num_errors = 0;
    tests_run = 0;
    t_reset(1'b0, 1'b0);
    t_reset(1'b0, 1'b1);
    t_reset(1'b1, 1'b1);
    t_reset(1'b1, 1'b0);
    t_table(1'b0, 4'h0);
    t_table(1'b1, 4'h3);
    t_mask_order();
    give_verdict();
  end
endmodule
